// file: pcsu_chk.sv
// Purpose: Port-level checker for the prioritize, CRC and status unit
// Assumes: One clock, synchronous active-high reset
// Notes: Register file is hidden, so CRC checks lean on link and acc
`timescale 1ns/1ps
module pcsu_chk
	import pcsu_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] instr,
	input wire logic [3:0] tbus_in,
	input wire logic [15:0] y_out,
	input wire logic y_oe,
	input wire logic [15:0] acc_out,
	input wire logic [7:0] processor_status_byte,
	input wire logic condition_test_output
);
	logic [7:0] st;
	logic [3:0] fa;
	logic [3:0] fb;
	logic [15:0] cv;
	logic [7:0] bits;
	logic nr;
	logic tst;
	logic mask_all_one;
	logic crc;
	logic setb;
	logic clrb;
	// Field decode of the presented word
	assign st = processor_status_byte;
	assign fa = instr[12:9];
	assign fb = instr[8:5];
	assign nr = instr[14:13] == 2'h3;
	assign tst = !instr[15] && nr && fa == 4'h9 && fb == 4'ha && !instr[0];
	assign mask_all_one = instr[14] && (fa == 4'h8 || fa[3:1] == 3'h5) && (fb == 4'h4 || fb == 4'h6
		|| (!nr && fb == 4'h3)) && (!nr || instr[4:1] == 4'h0);
	assign crc = instr[15:13] == 3'h6 && fa == 4'h6 && (fb == 4'h3 || fb == 4'h9);
	assign setb = !instr[15] && nr && fa == 4'hb && fb == 4'ha;
	assign clrb = !instr[15] && nr && fa == 4'ha && fb == 4'ha;
	// Condition table by selection code; codes above eleven read low
	assign cv = {4'h0, st[7:4], st[2], st[0] | ~st[1], st[1], 1'b0, st[3], st[0],
		st[2] ^ st[3], (st[2] ^ st[3]) | st[0]};
	// Bits a set or reset opcode may touch; group codes differ per direction
	always_comb begin
		case (instr[4:0])
			5'h05: bits = 8'h10;
			5'h06: bits = 8'h20;
			5'h09: bits = 8'h40;
			5'h0a: bits = 8'h80;
			default: bits = (instr[4:0] == (setb ? 5'h01 : 5'h03)) ? 8'h0f : 8'h00;
		endcase
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	AST_COND_INSTR: assert property (tst |-> condition_test_output == cv[instr[4:1]])
		else $error("condition ignores test word");
	AST_COND_TBUS: assert property (!tst |-> condition_test_output == cv[tbus_in])
		else $error("condition ignores test bus");
	AST_PRIO_FLAGS: assert property (mask_all_one |=> y_oe && st[3:1] == 3'h0 && $stable(st[7:4]))
		else $error("prioritize flags wrong");
	AST_PRIO_WORD: assert property (mask_all_one && instr[15] && !nr |=>
		y_out[15:5] == 11'h000 && st[0] == (y_out == 16'h0000)) else $error("word code wrong");
	AST_PRIO_BYTE: assert property (mask_all_one && !instr[15] && !nr |=>
		y_out[15:3] == 13'h0000) else $error("byte code too wide");
	AST_PRIO_ACC: assert property (mask_all_one && nr && instr[0] && instr[15] |=>
		acc_out[15:5] == 11'h000 && st[0] == (acc_out == 16'h0000)) else $error("acc code wrong");
	AST_CRC_FLAGS: assert property (crc |=> y_oe && st[3] == 1'b0 && st[1] == 1'b0 &&
		st[2] == y_out[15] && st[0] == (y_out == 16'h0000) && $stable(st[7:5]))
		else $error("crc flags wrong");
	AST_CRC_FWD: assert property (crc && fb == 4'h3 |=> $stable(acc_out) &&
		y_out[0] == (($past(st[4]) ^ st[4]) & $past(acc_out[0]))) else $error("forward bit 0");
	AST_CRC_REV: assert property (crc && fb == 4'h9 |=> $stable(acc_out) &&
		y_out[15] == (($past(st[4]) ^ st[4]) & $past(acc_out[15]))) else $error("reverse bit 15");
	AST_SET: assert property (setb && bits != 8'h00 |=>
		st == ($past(st) | $past(bits))) else $error("set touched wrong bits");
	AST_CLR: assert property (clrb && bits != 8'h00 |=>
		st == ($past(st) & ~$past(bits))) else $error("reset touched wrong bits");
	AST_SAVE: assert property (instr[15:13] == 3'h7 && fa == 4'h7 && fb == 4'ha &&
		instr[4:0] == 5'h01 |=> acc_out == {8'h00, $past(st)} && $stable(st))
		else $error("word save wrong");
endmodule
bind pcsu_top pcsu_chk u_chk (.clk(clk), .rst(rst), .instr(instr), .tbus_in(tbus_in),
	.y_out(y_out), .y_oe(y_oe), .acc_out(acc_out),
	.processor_status_byte(processor_status_byte), .condition_test_output(condition_test_output));

// file: pcsu_condition.sv
// Purpose: Selects one of twelve conditions for the condition test output
// Assumes: Status byte from the register
// Notes: Codes above eleven read low
`timescale 1ns/1ps
module pcsu_condition
	import pcsu_pkg::*;
(
	input wire logic [3:0] sel,
	input wire logic [7:0] st,
	output logic cond
);
	// Condition multiplexer
	always_comb begin
		case (sel) // [RL19]
			TEST_LESSEQUAL_SIGNED: cond = (st[ST_N] ^ st[ST_OVR]) | st[ST_Z];
			TEST_LESS_SIGNED: cond = st[ST_N] ^ st[ST_OVR];
			PCSU_T_Z: cond = st[ST_Z];
			PCSU_T_OVR: cond = st[ST_OVR];
			TEST_CONSTANT_LOW: cond = 1'b0;
			PCSU_T_C: cond = st[ST_C];
			TEST_LOWEREQUAL_UNSIGNED: cond = st[ST_Z] | ~st[ST_C];
			PCSU_T_N: cond = st[ST_N];
			PCSU_T_LINK: cond = st[ST_LINK];
			PCSU_T_F1: cond = st[ST_F1];
			PCSU_T_F2: cond = st[ST_F2];
			PCSU_T_F3: cond = st[ST_F3];
			default: cond = 1'b0;
		endcase
	end
endmodule

// file: pcsu_dec_if.sv
// Purpose: Carries decoded instruction between decoder and datapath
// Assumes: Single clock domain
// Notes: Purely combinational bundle
`timescale 1ns/1ps
interface pcsu_dec_if;
	import pcsu_pkg::*;
	pcsu_op_t op;
	pcsu_dst_t dst;
	logic [3:0] mask_sel;
	logic [3:0] opnd_sel;
	logic [4:0] ram_addr;
	logic byte_mode;
	logic test_valid;
	logic [3:0] test_sel;
	logic y_drive;
	modport dec (output op, dst, mask_sel, opnd_sel, ram_addr, byte_mode, test_valid,
		test_sel, y_drive);
	modport dp (input op, dst, mask_sel, opnd_sel, ram_addr, byte_mode, test_valid,
		test_sel, y_drive);
endinterface

// file: pcsu_decoder.sv
// Purpose: Decodes the instruction word into operation, sources and destination
// Assumes: Instruction word stable through the cycle
// Notes: Unrecognised words decode to no operation
`timescale 1ns/1ps
module pcsu_decoder
	import pcsu_pkg::*;
(
	input wire logic [15:0] instr,
	pcsu_dec_if.dec d
);
	logic bw;
	logic [1:0] quad;
	logic [3:0] fa;
	logic [3:0] fb;
	logic [4:0] lo;

	assign bw = instr[PCSU_BW_BIT];
	assign quad = instr[PCSU_QUAD_HI:PCSU_QUAD_LO];
	assign fa = instr[PCSU_FA_HI:PCSU_FA_LO];
	assign fb = instr[PCSU_FB_HI:PCSU_FB_LO];
	assign lo = instr[PCSU_LOW_HI:0];

	function automatic logic mask_ok(input logic [3:0] m);
		return (m == MASK_FROM_ACCUMULATOR) || (m == MASK_ALL_ZERO) || (m == MASK_ALL_ONE);
	endfunction

	// Field decode, quad first
	always_comb begin
		d.op = PCSU_OP_NONE;
		d.dst = PCSU_DST_NONE;
		d.mask_sel = fa;
		d.opnd_sel = fb;
		d.ram_addr = lo;
		d.byte_mode = ~bw;
		d.test_valid = 1'b0;
		d.test_sel = lo[4:1];
		d.y_drive = 1'b0;
		if (quad == PCSU_QUAD_RAM) begin
			if (bw && fa == PCSU_CRC_FA && fb == CRC_STEP_FORWARD) begin
				d.op = PCSU_OP_CRC_STEP_FORWARD; // [RL11]
				d.dst = PCSU_DST_RAM;
				d.y_drive = 1'b1;
			end else if (bw && fa == PCSU_CRC_FA && fb == CRC_STEP_REVERSE) begin
				d.op = PCSU_OP_CRC_STEP_REVERSE; // [RL11]
				d.dst = PCSU_DST_RAM;
				d.y_drive = 1'b1;
			end else if (fa == PCSU_SAVE_FA && fb == PCSU_STAT_FB) begin
				d.op = PCSU_OP_SAVE; // [RL17]
				d.dst = PCSU_DST_RAM;
				d.y_drive = 1'b1;
			end else if (mask_ok(fa) && (fb == OPERAND_FROM_RAM_T3 ||
				fb == OPERAND_FROM_ACC_T3 || fb == OPERAND_FROM_DATA_T3)) begin
				d.op = PCSU_OP_PRIO; // [RL1]
				d.dst = PCSU_DST_RAM;
				d.y_drive = 1'b1;
			end
		end else if (quad == PCSU_QUAD_NONRAM) begin
			if (!bw && fb == PCSU_STAT_FB && fa == FORCE_FLAGS_HIGH) begin
				d.op = PCSU_OP_SET; // [RL15]
			end else if (!bw && fb == PCSU_STAT_FB && fa == FORCE_FLAGS_LOW) begin
				d.op = PCSU_OP_RST; // [RL15]
			end else if (!bw && fb == PCSU_STAT_FB && fa == PCSU_TEST_FA && !lo[0]) begin
				d.test_valid = 1'b1; // [RL20]
			end else if ((lo == RESULT_TO_YBUS || lo == RESULT_TO_ACCUMULATOR) &&
				((fa == PCSU_SAVE_FA && fb == PCSU_STAT_FB) || (mask_ok(fa) &&
				(fb == OPERAND_FROM_ACC_T3 || fb == OPERAND_FROM_DATA_T3)))) begin
				d.op = (fa == PCSU_SAVE_FA) ? PCSU_OP_SAVE : PCSU_OP_PRIO; // [RL2] [RL17]
				d.dst = (lo == RESULT_TO_ACCUMULATOR) ? PCSU_DST_ACC : PCSU_DST_NONE;
				d.y_drive = 1'b1;
			end
		end
	end
endmodule

// file: pcsu_pkg.sv
// Purpose: Shared constants and types for the prioritize, CRC and status unit
// Assumes: 16-bit instruction word, fields at [15],[14:13],[12:9],[8:5],[4:0]
// Notes: Status byte layout and opcode encodings live here only
package pcsu_pkg;

	localparam int unsigned PCSU_W = 16;
	localparam int unsigned PCSU_RAM_DEPTH = 32;

	// Instruction word field positions
	localparam int unsigned PCSU_BW_BIT = 15;
	localparam int unsigned PCSU_QUAD_HI = 14;
	localparam int unsigned PCSU_QUAD_LO = 13;
	localparam int unsigned PCSU_FA_HI = 12;
	localparam int unsigned PCSU_FA_LO = 9;
	localparam int unsigned PCSU_FB_HI = 8;
	localparam int unsigned PCSU_FB_LO = 5;
	localparam int unsigned PCSU_LOW_HI = 4;

	// Quads
	localparam logic [1:0] PCSU_QUAD_RAM = 2'h2;
	localparam logic [1:0] PCSU_QUAD_NONRAM = 2'h3;

	// Mask selector codes
	localparam logic [3:0] MASK_FROM_ACCUMULATOR = 4'h8;
	localparam logic [3:0] MASK_ALL_ZERO = 4'ha;
	localparam logic [3:0] MASK_ALL_ONE = 4'hb;

	// Operand selector codes
	localparam logic [3:0] OPERAND_FROM_RAM_T3 = 4'h3;
	localparam logic [3:0] OPERAND_FROM_ACC_T3 = 4'h4;
	localparam logic [3:0] OPERAND_FROM_DATA_T3 = 4'h6;

	// Non-RAM destinations
	localparam logic [4:0] RESULT_TO_YBUS = 5'h00;
	localparam logic [4:0] RESULT_TO_ACCUMULATOR = 5'h01;

	// CRC, save and status field codes
	localparam logic [3:0] PCSU_CRC_FA = 4'h6;
	localparam logic [3:0] CRC_STEP_FORWARD = 4'h3;
	localparam logic [3:0] CRC_STEP_REVERSE = 4'h9;
	localparam logic [3:0] PCSU_SAVE_FA = 4'h7;
	localparam logic [3:0] PCSU_STAT_FB = 4'ha;
	localparam logic [3:0] FORCE_FLAGS_HIGH = 4'hb;
	localparam logic [3:0] FORCE_FLAGS_LOW = 4'ha;
	localparam logic [3:0] PCSU_TEST_FA = 4'h9;

	// Status opcodes
	localparam logic [4:0] SET_ARITH_FLAG_GROUP = 5'h01;
	localparam logic [4:0] CLEAR_ARITH_FLAG_GROUP = 5'h03;
	localparam logic [4:0] PCSU_OP_LINK = 5'h05;
	localparam logic [4:0] PCSU_OP_FLAG1 = 5'h06;
	localparam logic [4:0] PCSU_OP_FLAG2 = 5'h09;
	localparam logic [4:0] PCSU_OP_FLAG3 = 5'h0a;

	// Status byte bit positions
	localparam int unsigned ST_Z = 0;
	localparam int unsigned ST_C = 1;
	localparam int unsigned ST_N = 2;
	localparam int unsigned ST_OVR = 3;
	localparam int unsigned ST_LINK = 4;
	localparam int unsigned ST_F1 = 5;
	localparam int unsigned ST_F2 = 6;
	localparam int unsigned ST_F3 = 7;
	localparam logic [7:0] PCSU_STATUS_RESET = 8'h00;
	localparam logic [7:0] PCSU_ARITH_GROUP = 8'h0f;

	// Condition test selection codes
	localparam logic [3:0] TEST_LESSEQUAL_SIGNED = 4'h0;
	localparam logic [3:0] TEST_LESS_SIGNED = 4'h1;
	localparam logic [3:0] PCSU_T_Z = 4'h2;
	localparam logic [3:0] PCSU_T_OVR = 4'h3;
	localparam logic [3:0] TEST_CONSTANT_LOW = 4'h4;
	localparam logic [3:0] PCSU_T_C = 4'h5;
	localparam logic [3:0] TEST_LOWEREQUAL_UNSIGNED = 4'h6;
	localparam logic [3:0] PCSU_T_N = 4'h7;
	localparam logic [3:0] PCSU_T_LINK = 4'h8;
	localparam logic [3:0] PCSU_T_F1 = 4'h9;
	localparam logic [3:0] PCSU_T_F2 = 4'ha;
	localparam logic [3:0] PCSU_T_F3 = 4'hb;

	localparam logic [15:0] PCSU_ZERO16 = 16'h0000;
	localparam logic [15:0] PCSU_ONES16 = 16'hffff;

	typedef enum logic [6:0] {
		PCSU_OP_NONE = 7'b000_0001,
		PCSU_OP_PRIO = 7'b000_0010,
		PCSU_OP_CRC_STEP_FORWARD = 7'b000_0100,
		PCSU_OP_CRC_STEP_REVERSE = 7'b000_1000,
		PCSU_OP_SET = 7'b001_0000,
		PCSU_OP_RST = 7'b010_0000,
		PCSU_OP_SAVE = 7'b100_0000
	} pcsu_op_t;

	typedef enum logic [2:0] {
		PCSU_DST_NONE = 3'b001,
		PCSU_DST_RAM = 3'b010,
		PCSU_DST_ACC = 3'b100
	} pcsu_dst_t;

endpackage

// file: pcsu_seq_model.sv
// Purpose: Microprogram sequencer model feeding words and sampling the condition
// Assumes: Words change just after the falling edge
// Notes: Slow mode slips an idle word in front of the next request
`timescale 1ns/1ps
module pcsu_seq_model (
	input wire logic clk,
	output logic [15:0] instr,
	output logic [15:0] data_in,
	output logic [3:0] tbus_sel,
	input wire logic cond,
	output logic cond_seen
);
	localparam logic [15:0] IDLE_WORD = 16'h7140;
	// Idle word at start so reset sees nothing that writes
	initial begin
		instr = IDLE_WORD;
		data_in = 16'h0000;
		tbus_sel = 4'h4;
	end
	// Condition taken with each instruction edge
	always @(posedge clk) begin
		cond_seen <= cond;
	end
	// One word per cycle; idle cycles scramble data so stale values show
	task automatic issue(input logic [15:0] w, input logic [15:0] d, input logic [3:0] t,
		input logic slow);
		if (slow) begin
			@(negedge clk);
			instr = IDLE_WORD;
			data_in = ~data_in;
			tbus_sel = ~tbus_sel;
		end
		@(negedge clk);
		instr = w;
		data_in = d;
		tbus_sel = t;
	endtask
endmodule

// file: pcsu_top.sv
// Purpose: Prioritize, CRC step and status operations of a 16-bit datapath
// Assumes: Instruction word and data input synchronous to clk
// Notes: One instruction per cycle, results written on the clock edge
// How it works
// [RL1] RAM prioritize: mask from accumulator, zeros or ones; operand RAM, acc or data
// [RL2] Non-RAM prioritize: operand acc or data; result to Y bus or accumulator
// [RL3] Word prioritize encodes sixteen bits into result bits 4..0, rest zero
// [RL4] Byte prioritize encodes bits 7..0 into result bits 2..0 upward zero
// [RL5] Prioritize updates N and Z, clears OVERFLOW_FLAG and C, keeps others
// [RL6] CRC uses accumulator as polynomial mask, RAM register as remainder
// [RL7] Forward step: feedback link xor bit15, shift up with masked feedback
// [RL8] Reverse step: feedback link xor bit0, shift down with masked feedback
// [RL9] Link receives the bit shifted out of the checksum
// [RL10] CRC updates link, N, Z; clears OVERFLOW_FLAG, C; keeps user flags
// [RL11] CRC decodes word, quad 10, 0110 then 0011 or 1001, RAM address
// [RL12] Status byte: F3 F2 F1 LINK OVERFLOW_FLAG N C Z from bit 7 down
// [RL13] Set status forces only the chosen bit or group high
// [RL14] Reset status forces only the chosen bit or group low
// [RL15] Set 1011/1010, reset 1010/1010, quad 11, byte; opcode picks bits
// [RL16] Save status writes low byte; upper kept in byte, zeroed in word
// [RL17] Save to RAM quad 10 0111 1010; non-RAM quad 11 to Y or acc
// [RL18] Test drives condition output with one of twelve conditions
// [RL19] Test code map from signed compares through user flags
// [RL20] Test decodes quad 11 1001 1010, code in opcode bits 4..1
// [RL21] Without a test instruction the test bus selects the condition
// [RL22] Instruction test selection beats the test bus
// [RL23] One cycle per instruction; condition output combinational
`timescale 1ns/1ps
module pcsu_top
	import pcsu_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] instr,
	input wire logic [15:0] data_in,
	input wire logic [3:0] tbus_in,
	output logic [3:0] tbus_out,
	output logic [3:0] tbus_oe,
	output logic [15:0] y_out,
	output logic y_oe,
	output logic [15:0] acc_out,
	output logic [7:0] processor_status_byte,
	output logic condition_test_output
);
	pcsu_dec_if d();

	logic [PCSU_W-1:0] ram_r [PCSU_RAM_DEPTH];
	logic [PCSU_W-1:0] acc_r;
	logic [PCSU_W-1:0] acc_nxt;
	logic [7:0] st_r;
	logic [7:0] st_nxt;
	logic [PCSU_W-1:0] y_r;
	logic [PCSU_W-1:0] y_nxt;
	logic y_oe_r;
	logic ram_we;
	logic [PCSU_W-1:0] ram_wdata;
	logic [PCSU_W-1:0] ram_q;
	logic [PCSU_W-1:0] mask_v;
	logic [PCSU_W-1:0] opnd_v;
	logic [PCSU_W-1:0] prio_v;
	logic [PCSU_W-1:0] crc_v;
	logic [PCSU_W-1:0] save_v;
	logic [PCSU_W-1:0] res_v;
	logic crc_out_bit;
	logic [7:0] grp;
	logic [3:0] cond_sel;

	pcsu_decoder u_dec (
		.instr(instr),
		.d(d)
	);

	// Zero flag on the width in use
	function automatic logic is_zero(input logic [15:0] v, input logic bm);
		return bm ? (v[7:0] == 8'h00) : (v == PCSU_ZERO16);
	endfunction

	// Sign on the width in use
	function automatic logic sign_of(input logic [15:0] v, input logic bm);
		return bm ? v[7] : v[15];
	endfunction

	// Priority code: highest active bit scores 1, lowest scores width in word mode and zero in byte mode
	function automatic logic [4:0] prio_code(input logic [15:0] v, input logic bm);
		logic [4:0] c;
		c = 5'h00;
		if (bm) begin
			for (int i = 0; i < 8; i++) begin
				if (v[i]) begin
					// Code eight wraps to zero: only three result bits exist in byte mode
					c = 5'(8 - i) & 5'h07; // [RL4]
				end
			end
		end else begin
			for (int i = 0; i < 16; i++) begin
				if (v[i]) begin
					c = 5'(16 - i); // [RL3]
				end
			end
		end
		return c;
	endfunction

	assign ram_q = ram_r[d.ram_addr];

	// Mask and operand sources
	always_comb begin
		case (d.mask_sel) // [RL1]
			MASK_FROM_ACCUMULATOR: mask_v = acc_r;
			MASK_ALL_ZERO: mask_v = PCSU_ZERO16;
			MASK_ALL_ONE: mask_v = PCSU_ONES16;
			default: mask_v = PCSU_ZERO16;
		endcase
		case (d.opnd_sel) // [RL1] [RL2]
			OPERAND_FROM_RAM_T3: opnd_v = ram_q;
			OPERAND_FROM_ACC_T3: opnd_v = acc_r;
			OPERAND_FROM_DATA_T3: opnd_v = data_in;
			default: opnd_v = data_in;
		endcase
	end

	// Prioritize result, upper bits zero
	assign prio_v = {11'h000, prio_code(opnd_v & ~mask_v, d.byte_mode)}; // [RL3] [RL4]

	// CRC step: accumulator is polynomial, RAM holds remainder
	always_comb begin
		logic fb;
		fb = 1'b0;
		crc_v = PCSU_ZERO16;
		crc_out_bit = 1'b0;
		if (d.op == PCSU_OP_CRC_STEP_REVERSE) begin
			fb = st_r[ST_LINK] ^ ram_q[0]; // [RL8]
			crc_v = ({16{fb}} & acc_r) ^ {1'b0, ram_q[15:1]}; // [RL8] [RL6]
			crc_out_bit = ram_q[0]; // [RL9]
		end else begin
			fb = st_r[ST_LINK] ^ ram_q[15]; // [RL7]
			crc_v = ({16{fb}} & acc_r) ^ {ram_q[14:0], 1'b0}; // [RL7] [RL6]
			crc_out_bit = ram_q[15]; // [RL9]
		end
	end

	// Save value: status in low byte, upper zero on the bus
	assign save_v = {8'h00, st_r}; // [RL16]

	// Bit group chosen by a status opcode
	always_comb begin
		case (d.ram_addr) // [RL15]
			SET_ARITH_FLAG_GROUP: grp = (d.op == PCSU_OP_SET) ? PCSU_ARITH_GROUP : 8'h00;
			CLEAR_ARITH_FLAG_GROUP: grp = (d.op == PCSU_OP_RST) ? PCSU_ARITH_GROUP : 8'h00;
			PCSU_OP_LINK: grp = 8'(1 << ST_LINK);
			PCSU_OP_FLAG1: grp = 8'(1 << ST_F1);
			PCSU_OP_FLAG2: grp = 8'(1 << ST_F2);
			PCSU_OP_FLAG3: grp = 8'(1 << ST_F3);
			default: grp = 8'h00;
		endcase
	end

	// Next state of accumulator, status, RAM and Y bus
	always_comb begin
		res_v = PCSU_ZERO16;
		acc_nxt = acc_r;
		st_nxt = st_r;
		ram_we = 1'b0;
		ram_wdata = ram_q;
		y_nxt = y_r;
		case (d.op)
			PCSU_OP_PRIO: begin
				res_v = prio_v;
				st_nxt[ST_N] = sign_of(res_v, d.byte_mode); // [RL5]
				st_nxt[ST_Z] = is_zero(res_v, d.byte_mode); // [RL5]
				st_nxt[ST_OVR] = 1'b0; // [RL5]
				st_nxt[ST_C] = 1'b0; // [RL5]
			end
			PCSU_OP_CRC_STEP_FORWARD, PCSU_OP_CRC_STEP_REVERSE: begin
				res_v = crc_v;
				st_nxt[ST_LINK] = crc_out_bit; // [RL9] [RL10]
				st_nxt[ST_N] = res_v[15]; // [RL10]
				st_nxt[ST_Z] = (res_v == PCSU_ZERO16); // [RL10]
				st_nxt[ST_OVR] = 1'b0; // [RL10]
				st_nxt[ST_C] = 1'b0; // [RL10]
			end
			PCSU_OP_SET: begin
				res_v = PCSU_ONES16;
				st_nxt = st_r | grp; // [RL13]
			end
			PCSU_OP_RST: begin
				res_v = PCSU_ZERO16;
				st_nxt = st_r & ~grp; // [RL14]
			end
			PCSU_OP_SAVE: begin
				res_v = save_v;
			end
			default: begin
				res_v = PCSU_ZERO16;
			end
		endcase
		// Byte mode keeps the upper byte of the destination
		if (d.op == PCSU_OP_SAVE || d.op == PCSU_OP_PRIO) begin
			if (d.dst == PCSU_DST_RAM) begin
				ram_we = 1'b1;
				ram_wdata = d.byte_mode ? {ram_q[15:8], res_v[7:0]} : res_v; // [RL16]
			end else if (d.dst == PCSU_DST_ACC) begin
				acc_nxt = d.byte_mode ? {acc_r[15:8], res_v[7:0]} : res_v; // [RL16] [RL2]
			end
		end else if (d.op == PCSU_OP_CRC_STEP_FORWARD || d.op == PCSU_OP_CRC_STEP_REVERSE) begin
			ram_we = 1'b1; // [RL6]
			ram_wdata = res_v;
		end
		if (d.y_drive) begin
			y_nxt = res_v; // [RL2]
		end
	end

	// Registers update on the edge, one instruction per cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_r <= PCSU_ZERO16;
			st_r <= PCSU_STATUS_RESET;
			y_r <= PCSU_ZERO16;
			y_oe_r <= 1'b0;
		end else begin
			acc_r <= acc_nxt; // [RL23]
			st_r <= st_nxt; // [RL23]
			y_r <= y_nxt;
			y_oe_r <= d.y_drive;
		end
	end

	// RAM file has no reset; contents are software state
	always_ff @(posedge clk) begin
		if (ram_we) begin
			ram_r[d.ram_addr] <= ram_wdata;
		end
	end

	// Instruction test wins over the test bus
	assign cond_sel = d.test_valid ? d.test_sel : tbus_in; // [RL21] [RL22]

	pcsu_condition u_cond (
		.sel(cond_sel),
		.st(st_r),
		.cond(condition_test_output) // [RL18] [RL23]
	);

	// Test bus is only ever an input here; outputs parked low
	assign tbus_out = 4'h0;
	assign tbus_oe = 4'h0;
	assign y_out = y_r;
	assign y_oe = y_oe_r;
	assign acc_out = acc_r;
	assign processor_status_byte = st_r; // [RL12]
endmodule

// file: prio_crc_status_unit_tb_top.sv
// Purpose: Self-checking bench with random instruction mix
// Assumes: Status byte and acc read at the falling edge
// Notes: Register file mirrored here, seen only through results
`timescale 1ns/1ps
module prio_crc_status_unit_tb_top;
	import pcsu_pkg::*;
	typedef struct {logic [15:0] y; logic [15:0] a; logic [7:0] s; logic cy;} pcsu_note_t;
	logic clk;
	logic rst;
	logic [15:0] instr;
	logic [15:0] data_in;
	logic [3:0] seq_t;
	logic [3:0] tbus_w;
	logic [3:0] tbus_out;
	logic [3:0] tbus_oe;
	logic [15:0] y_out;
	logic y_oe;
	logic [15:0] acc_out;
	logic [7:0] processor_status_byte;
	logic condition_test_output;
	int n_mismatch = 0;
	int comparisons = 0;
	logic [31:0] seed;
	logic [15:0] d_cur;
	logic [15:0] acc_m;
	logic [7:0] st_m;
	logic [15:0] ram_m [32];
	pcsu_note_t notes[$];
	pcsu_note_t mn;
	logic [3:0] mtab [3] = '{4'h8, 4'ha, 4'hb};
	logic [4:0] stab [5] = '{5'h01, 5'h05, 5'h06, 5'h09, 5'h0a};
	logic [7:0] smsk [5] = '{8'h0f, 8'h10, 8'h20, 8'h40, 8'h80};
	logic [2:0] k;
	logic [4:0] a5;
	logic [3:0] ms;
	logic [3:0] s;
	logic [3:0] x;
	logic [4:0] op;
	logic [15:0] r;
	logic [15:0] res;
	logic bw;
	logic fbk;
	int j;
	// Two-way test bus: design wins only where it enables
	assign tbus_w = (tbus_oe & tbus_out) | (~tbus_oe & seq_t);
	pcsu_top u_dut (.clk(clk), .rst(rst), .instr(instr), .data_in(data_in), .tbus_in(tbus_w),
		.tbus_out(tbus_out), .tbus_oe(tbus_oe), .y_out(y_out), .y_oe(y_oe), .acc_out(acc_out),
		.processor_status_byte(processor_status_byte),
		.condition_test_output(condition_test_output));
	pcsu_seq_model u_seq (.clk(clk), .instr(instr), .data_in(data_in), .tbus_sel(seq_t),
		.cond(condition_test_output), .cond_seen());
	always #25 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	function automatic logic cnd(input logic [3:0] c, input logic [7:0] q);
		logic [15:0] v;
		v = {4'h0, q[7:4], q[2], q[0] | ~q[1], q[1], 1'b0, q[3], q[0], q[2] ^ q[3],
			(q[2] ^ q[3]) | q[0]};
		return v[c];
	endfunction
	// Highest active bit wins; byte code keeps three bits only
	function automatic logic [15:0] pcode(input logic [15:0] v, input logic b);
		pcode = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			if (v[i] && (b || i < 8)) begin
				pcode = b ? 16'(16 - i) : 16'((8 - i) & 7);
			end
		end
	endfunction
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic push(input logic [15:0] y, input logic cy);
		notes.push_back(pcsu_note_t'{y, acc_m, st_m, cy});
	endtask
	// Issue one word; condition checked against status before it executes
	task automatic go(input logic [15:0] w);
		logic [3:0] t;
		seed = xs(seed);
		d_cur = seed[15:0];
		t = seed[19:16];
		u_seq.issue(w, d_cur, t, seed[20]);
		if (w[15:5] == {1'b0, 2'h3, 4'h9, 4'ha} && !w[0]) t = w[4:1];
		#1;
		chk("cond", 16'(condition_test_output), 16'(cnd(t, st_m)));
		chk("tbus_drive", 16'({tbus_oe, tbus_out}), 16'h0000);
	endtask
	task automatic prio(input logic [15:0] v, output logic [15:0] rs);
		logic [15:0] m;
		m = ms == 4'h8 ? acc_m : (ms == 4'ha ? 16'h0000 : 16'hffff);
		rs = pcode(v & ~m, bw);
		st_m[3:0] = {3'h0, bw ? rs == 16'h0000 : rs[7:0] == 8'h00};
	endtask
	task automatic complete_run;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Result watcher: each producing cycle retires the oldest note
	always @(negedge clk) begin
		if (!rst && y_oe !== 1'b0) begin
			if (notes.size() == 0) begin
				chk("y_oe", 16'(y_oe), 16'h0000);
			end else begin
				mn = notes.pop_front();
				if (mn.cy) chk("y_out", y_out, mn.y);
				chk("acc", acc_out, mn.a);
				chk("status", 16'(processor_status_byte), 16'(mn.s));
			end
		end
	end
	// Hang guard, well past the expected run
	initial begin
		#200000;
		n_mismatch++;
		complete_run();
	end
	// Reset, fill the register file, then a random instruction mix
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		seed = 32'h0000_18ce;
		acc_m = 16'h0000;
		st_m = 8'h00;
		repeat (8) @(negedge clk);
		chk("acc", acc_out, 16'h0000);
		chk("status", 16'(processor_status_byte), 16'h0000);
		chk("y_oe", 16'(y_oe), 16'h0000);
		rst = 1'b0;
		for (int i = 0; i < 32; i++) begin
			go({1'b1, 2'h2, 4'h7, 4'ha, 5'(i)});
			ram_m[i] = 16'h0000;
			push(16'h0000, 1'b1);
		end
		for (int it = 0; it < 400; it++) begin
			seed = xs(seed);
			k = seed[2:0];
			a5 = seed[8:4];
			bw = seed[9];
			ms = mtab[seed[11:10] % 3];
			x = seed[15:12];
			j = seed[14:12] % 5;
			s = (x[1:0] == 2'h0 || (ms == 4'h8 && x[1:0] == 2'h1)) ? 4'h3 : (x[1] ? 4'h6 : 4'h4);
			case (k)
				3'h0, 3'h1: begin
					op = (k[0] && j == 0) ? 5'h03 : stab[j];
					go({1'b0, 2'h3, k[0] ? 4'ha : 4'hb, 4'ha, op});
					st_m = k[0] ? st_m & ~smsk[j] : st_m | smsk[j];
				end
				3'h2: begin
					go({bw, 2'h2, ms, s, a5});
					prio(s == 4'h3 ? ram_m[a5] : (s == 4'h4 ? acc_m : d_cur), res);
					ram_m[a5] = bw ? res : {ram_m[a5][15:8], res[7:0]};
					push(res, 1'b1);
				end
				3'h3: begin
					s = (x[2] || ms == 4'h8) ? 4'h6 : 4'h4;
					go({bw, 2'h3, ms, s, 4'h0, x[3]});
					prio(s == 4'h4 ? acc_m : d_cur, res);
					if (x[3]) acc_m = bw ? res : {acc_m[15:8], res[7:0]};
					// Y bus carries the code even when the accumulator is loaded
					push(res, 1'b1);
				end
				3'h4: begin
					go({1'b1, 2'h2, 4'h6, x[0] ? 4'h9 : 4'h3, a5});
					r = ram_m[a5];
					fbk = st_m[4] ^ (x[0] ? r[0] : r[15]);
					res = (x[0] ? {1'b0, r[15:1]} : {r[14:0], 1'b0}) ^
						(fbk ? acc_m : 16'h0000);
					st_m[4:0] = {x[0] ? r[0] : r[15], 1'b0, res[15], 1'b0,
						res == 16'h0000};
					ram_m[a5] = res;
					push(res, 1'b1);
				end
				3'h5: begin
					go({bw, x[0] ? 2'h3 : 2'h2, 4'h7, 4'ha,
						x[0] ? {4'h0, x[1]} : a5});
					r = {bw ? 8'h00 : (x[0] ? acc_m[15:8] : ram_m[a5][15:8]),
						st_m};
					if (!x[0]) ram_m[a5] = r;
					else if (x[1]) acc_m = r;
					push({8'h00, st_m}, 1'b1);
				end
				3'h6: go({1'b0, 2'h3, 4'h9, 4'ha, 4'(x % 12), 1'b0});
				default: go({1'b0, 2'h3, 4'h9, 4'ha, x, 1'b1});
			endcase
		end
		go(16'h7140);
		go(16'h7140);
		chk("pending", 16'(notes.size()), 16'h0000);
		complete_run();
	end
endmodule
